// >>> logic/icr_pkg.sv
// ==========================================================
// constants for the two-wire reservation and low-width block
package icr_pkg;
   // register addresses on the byte-wide processor port
   localparam logic [19:0] ADDR_CTL0 = 20'hF0230;
   localparam logic [19:0] ADDR_STAT = 20'hF0231;
   localparam logic [19:0] ADDR_LOW = 20'hF0232;
   localparam logic [19:0] ADDR_HIGH = 20'hF0233;
   localparam logic [19:0] ADDR_FLAG = 20'hF0234;
   localparam logic [19:0] ADDR_SHIFT = 20'hF0235;
   // control_reg0 bit positions
   localparam int CTL_ENABLE = 7;
   localparam int CTL_LEAVE = 6;
   localparam int CTL_STOP_IE = 4;
   localparam int CTL_START = 1;
   // flag_reg and bus_status_reg bit positions
   localparam int FLAG_RSV_DIS = 0;
   localparam int STAT_MASTER = 7;
   localparam int STAT_PENDING = 6;
   localparam int STAT_BUSY = 0;
   // reset values
   localparam logic [7:0] LOW_RESET = 8'hFF;
   localparam logic [7:0] HIGH_RESET = 8'hFF;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] FLAG_RESET = 8'h00;
   // bits per byte on the wire, data plus acknowledge
   localparam logic [3:0] BITS_PER_BYTE = 4'h9;
   // master sequencer states
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_WAIT = 3'b010,
      ST_LOW = 3'b011,
      ST_HIGH = 3'b100
   } icr_state_t;
endpackage : icr_pkg

// >>> logic/icr_line_if.sv
`timescale 1ns/1ps
// ==========================================================
// conditioned bus lines and bus events, monitor to sequencer
interface icr_line_if;
   logic scl_s; // synchronised clock line
   logic sda_s; // synchronised data line
   logic start_det; // start condition seen, one cycle
   logic stop_det; // stop condition seen, one cycle
   logic bus_busy; // start seen and no stop since
   modport mon (output scl_s, sda_s, start_det, stop_det, bus_busy);
   modport ctl (input scl_s, sda_s, start_det, stop_det, bus_busy);
endinterface : icr_line_if

// >>> logic/icr_bus_monitor.sv
`timescale 1ns/1ps
// ==========================================================
// line synchroniser and start/stop detector
module icr_bus_monitor
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic scl_pin,
   input wire logic sda_pin,
   icr_line_if.mon line
);
   // two-flop synchronisers, first stage read only by second
   logic scl_m_q, scl_s_q, sda_m_q, sda_s_q;
   // previous synchronised levels for edge finding
   logic scl_p_q, sda_p_q;
   logic busy_q;
   logic start_w, stop_w;

   // ==========================================================
   // synchronisers
   always_ff @(posedge sys_clk)
   begin
      scl_m_q <= scl_pin;
      scl_s_q <= scl_m_q;
      sda_m_q <= sda_pin;
      sda_s_q <= sda_m_q;
   end

   // data falls while clock high: start; data rises: stop
   assign start_w = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
   assign stop_w = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;

   // ==========================================================
   // history and busy tracking
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         busy_q <= 1'b0;
      end
      else
      begin
         scl_p_q <= scl_s_q;
         sda_p_q <= sda_s_q;
         if (start_w)
            busy_q <= 1'b1;
         else if (stop_w)
            busy_q <= 1'b0;
      end
   end

   assign line.scl_s = scl_s_q;
   assign line.sda_s = sda_s_q;
   assign line.start_det = start_w;
   assign line.stop_det = stop_w;
   assign line.bus_busy = busy_q;
endmodule : icr_bus_monitor

// >>> logic/icr_top.sv
`timescale 1ns/1ps
// Overview of operation
// - low width register sets clock low time
// - low width is byte-writable eight-bit register, writes ignored while interface enabled
// - low width resets to all ones
// - data hold is quarter of low width
// - reservation works only when disable flag clear
// - not in use: lost arbitration or left bus
// - start while idle after stop: start, wait
// - address after stop interrupt starts master transfer
// - shift writes before stop are discarded
// - start if released, else hold reservation
module icr_top
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [19:0] cpu_addr,
   input wire logic cpu_wr,
   input wire logic cpu_rd,
   input wire logic [7:0] cpu_wdata,
   output logic [7:0] cpu_rdata_q,
   input wire logic scl_in,
   output logic scl_out_q,
   output logic scl_oe_q,
   input wire logic sda_in,
   output logic sda_out_q,
   output logic sda_oe_q,
   output logic bus_event_irq_q
);
   // ==========================================================
   // registers and state
   logic [7:0] scl_low_width_q, scl_high_width_q; // clock widths
   logic [7:0] control_reg0_q, flag_reg_q; // control and flags
   logic [7:0] shift_reg_q; // byte to send
   logic master_q; // owns the bus
   logic rsv_pending_q; // reservation held
   logic stop_seen_q; // stop seen while reserved
   logic tx_req_q; // byte waiting to go
   logic [7:0] cnt_q; // phase counter
   logic [3:0] bit_q; // bit index in byte
   icr_pkg::icr_state_t state_q, state_d;

   icr_line_if line ();

   icr_bus_monitor u_mon
   (
      .sys_clk(sys_clk),
      .srst(srst),
      .scl_pin(scl_in),
      .sda_pin(sda_in),
      .line(line)
   );

   // ==========================================================
   // decode
   wire enable_w = control_reg0_q[icr_pkg::CTL_ENABLE];
   wire stop_ie_w = control_reg0_q[icr_pkg::CTL_STOP_IE];
   wire rsv_dis_w = flag_reg_q[icr_pkg::FLAG_RSV_DIS];
   wire wr_ctl = cpu_wr && (cpu_addr == icr_pkg::ADDR_CTL0);
   wire wr_low = cpu_wr && (cpu_addr == icr_pkg::ADDR_LOW);
   wire wr_high = cpu_wr && (cpu_addr == icr_pkg::ADDR_HIGH);
   wire wr_flag = cpu_wr && (cpu_addr == icr_pkg::ADDR_FLAG);
   wire wr_shift = cpu_wr && (cpu_addr == icr_pkg::ADDR_SHIFT);
   wire start_wr = wr_ctl && cpu_wdata[icr_pkg::CTL_START] && enable_w;
   wire leave_wr = wr_ctl && cpu_wdata[icr_pkg::CTL_LEAVE];
   // device not in use after arbitration loss or leaving the bus
   wire not_in_use = !master_q;
   wire bus_free = !line.bus_busy;
   wire launch_now = start_wr && not_in_use && bus_free;
   wire reserve = start_wr && not_in_use && !bus_free && !rsv_dis_w;
   // address written after stop report launches the master
   wire rsv_go = wr_shift && rsv_pending_q && stop_seen_q && stop_ie_w;
   wire drop_wr = wr_shift && rsv_pending_q && !stop_seen_q;
   wire tx_wr = wr_shift && master_q && !rsv_pending_q;
   wire launch = launch_now || rsv_go;
   // data hold is a quarter of the low width, at least one cycle
   wire [7:0] hold_w = (scl_low_width_q[7:2] == 6'h00) ? 8'h01 : {2'b00, scl_low_width_q[7:2]};
   wire low_done = (cnt_q >= scl_low_width_q);
   wire high_done = (cnt_q >= scl_high_width_q);
   wire data_bit = (bit_q < 4'h8) ? shift_reg_q[3'h7 - bit_q[2:0]] : 1'b1;
   // released data read low on a data bit: arbitration lost
   wire arb_lost = (state_q == icr_pkg::ST_HIGH) && line.scl_s && !sda_oe_q && !line.sda_s
                   && (bit_q < 4'h8);
   wire quit = arb_lost || leave_wr || !enable_w;

   // ==========================================================
   // sequencer next state
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         icr_pkg::ST_IDLE:
            if (launch)
               state_d = icr_pkg::ST_START;
         icr_pkg::ST_START:
            if (high_done)
               state_d = icr_pkg::ST_WAIT;
         icr_pkg::ST_WAIT:
            if (tx_req_q)
               state_d = icr_pkg::ST_LOW;
         icr_pkg::ST_LOW:
            if (low_done)
               state_d = icr_pkg::ST_HIGH;
         icr_pkg::ST_HIGH:
            if (line.scl_s && high_done)
               state_d = (bit_q == icr_pkg::BITS_PER_BYTE - 4'h1) ? icr_pkg::ST_WAIT : icr_pkg::ST_LOW;
         default:
            state_d = icr_pkg::ST_IDLE;
      endcase
      if (quit)
         state_d = icr_pkg::ST_IDLE;
   end

   // ==========================================================
   // sequencer registers, counter restarts on each state change
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         state_q <= icr_pkg::ST_IDLE;
         cnt_q <= 8'h00;
         bit_q <= 4'h0;
      end
      else
      begin
         state_q <= state_d;
         // high phase counts only once the line is seen high
         if (state_d != state_q)
            cnt_q <= 8'h00;
         else if (!(state_q == icr_pkg::ST_HIGH && !line.scl_s) && cnt_q != 8'hFF)
            cnt_q <= cnt_q + 8'h01;
         if (state_q == icr_pkg::ST_WAIT)
            bit_q <= 4'h0;
         else if (state_q == icr_pkg::ST_HIGH && state_d == icr_pkg::ST_LOW)
            bit_q <= bit_q + 4'h1;
      end
   end

   // ==========================================================
   // pin drivers: open drain, enable high pulls the line low
   always_ff @(posedge sys_clk)
   begin
      scl_out_q <= 1'b0;
      sda_out_q <= 1'b0;
      if (srst || state_d == icr_pkg::ST_IDLE)
      begin
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end
      else
      begin
         // clock low in wait and low phases
         scl_oe_q <= (state_d == icr_pkg::ST_WAIT) || (state_d == icr_pkg::ST_LOW);
         if (state_d == icr_pkg::ST_START)
            sda_oe_q <= 1'b1;
         else if (state_q == icr_pkg::ST_LOW && cnt_q == hold_w)
            sda_oe_q <= !data_bit;
      end
   end

   // ==========================================================
   // registers written by software, reservation tracking
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         scl_low_width_q <= icr_pkg::LOW_RESET;
         scl_high_width_q <= icr_pkg::HIGH_RESET;
         control_reg0_q <= icr_pkg::CTL_RESET;
         flag_reg_q <= icr_pkg::FLAG_RESET;
         shift_reg_q <= 8'h00;
         master_q <= 1'b0;
         rsv_pending_q <= 1'b0;
         stop_seen_q <= 1'b0;
         tx_req_q <= 1'b0;
         bus_event_irq_q <= 1'b0;
      end
      else
      begin
         // widths change only while the interface is off
         if (wr_low && !enable_w)
            scl_low_width_q <= cpu_wdata;
         if (wr_high && !enable_w)
            scl_high_width_q <= cpu_wdata;
         // trigger and leave bits do not stay set
         if (wr_ctl)
            control_reg0_q <= cpu_wdata & ~(8'h01 << icr_pkg::CTL_START) & ~(8'h01 << icr_pkg::CTL_LEAVE);
         if (wr_flag)
            flag_reg_q <= cpu_wdata;
         // discarded writes never reach the shifter
         if (rsv_go || tx_wr)
            shift_reg_q <= cpu_wdata;
         if (quit)
            master_q <= 1'b0;
         else if (launch)
            master_q <= 1'b1;
         if (quit || rsv_go)
            rsv_pending_q <= 1'b0;
         else if (reserve)
            rsv_pending_q <= 1'b1;
         if (!rsv_pending_q || quit || rsv_go)
            stop_seen_q <= 1'b0;
         else if (line.stop_det)
            stop_seen_q <= 1'b1;
         if (quit)
            tx_req_q <= 1'b0;
         else if (rsv_go || tx_wr)
            tx_req_q <= 1'b1;
         else if (state_q == icr_pkg::ST_WAIT)
            tx_req_q <= 1'b0;
         bus_event_irq_q <= line.stop_det && stop_ie_w;
      end
   end

   // ==========================================================
   // read port
   wire [7:0] stat_w = ({7'h00, master_q} << icr_pkg::STAT_MASTER)
                     | ({7'h00, rsv_pending_q} << icr_pkg::STAT_PENDING)
                     | ({7'h00, line.bus_busy} << icr_pkg::STAT_BUSY);
   wire [7:0] rd_mux = (cpu_addr == icr_pkg::ADDR_CTL0) ? control_reg0_q :
                       (cpu_addr == icr_pkg::ADDR_STAT) ? stat_w :
                       (cpu_addr == icr_pkg::ADDR_LOW) ? scl_low_width_q :
                       (cpu_addr == icr_pkg::ADDR_HIGH) ? scl_high_width_q :
                       (cpu_addr == icr_pkg::ADDR_FLAG) ? flag_reg_q :
                       (cpu_addr == icr_pkg::ADDR_SHIFT) ? shift_reg_q : 8'h00;

   always_ff @(posedge sys_clk)
   begin
      if (srst)
         cpu_rdata_q <= 8'h00;
      else if (cpu_rd)
         cpu_rdata_q <= rd_mux;
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   sequence s_free_req;
      start_wr && not_in_use && bus_free;
   endsequence
   sequence s_rsv_addr;
      wr_shift && rsv_pending_q && stop_seen_q && stop_ie_w;
   endsequence

   low_width_a: assert property ((state_q == icr_pkg::ST_LOW && state_d == icr_pkg::ST_HIGH && !quit)
      |-> cnt_q == scl_low_width_q) else $error("clock low phase length wrong");
   low_write_a: assert property ((wr_low && !enable_w) |=> scl_low_width_q == $past(cpu_wdata))
      else $error("low width write lost");
   low_reset_a: assert property (@(posedge sys_clk) $past(srst) |-> scl_low_width_q == 8'hFF)
      else $error("low width reset value wrong");
   data_hold_a: assert property (($changed(sda_oe_q) && $past(state_q) == icr_pkg::ST_LOW
      && state_q != icr_pkg::ST_IDLE) |-> $past(cnt_q) == $past(hold_w)) else $error("data hold wrong");
   rsv_enable_a: assert property ($rose(rsv_pending_q) |-> !$past(rsv_dis_w))
      else $error("reservation made while disabled");
   leave_bus_a: assert property (leave_wr |=> !master_q && !scl_oe_q && !sda_oe_q)
      else $error("bus not left");
   free_start_a: assert property (s_free_req |=> state_q == icr_pkg::ST_START ##1 sda_oe_q && master_q)
      else $error("start not generated");
   rsv_start_a: assert property (s_rsv_addr |=> master_q && tx_req_q && shift_reg_q == $past(cpu_wdata))
      else $error("reserved transfer not started");
   drop_write_a: assert property (drop_wr |=> $stable(shift_reg_q) && !tx_req_q)
      else $error("early shift write kept");
   busy_rsv_a: assert property ((start_wr && not_in_use && !bus_free && !rsv_dis_w)
      |=> rsv_pending_q && !master_q) else $error("reservation not held");
   stop_irq_a: assert property (bus_event_irq_q == $past(line.stop_det && stop_ie_w))
      else $error("stop interrupt mismatch");
endmodule : icr_top

// >>> sim/icr_bus_partner.sv
`timescale 1ns/1ps
// ==========================================================
// another master sharing the two-wire bus, lines pulled up
module icr_bus_partner
(
   input wire logic dev_scl_oe,
   input wire logic dev_sda_oe,
   output logic scl_line,
   output logic sda_line
);
   logic scl_pull = 1'b0; // partner holds clock low
   logic sda_pull = 1'b0; // partner holds data low
   // wired-and with pull-up; clock stands high between frames
   assign scl_line = ~(dev_scl_oe | scl_pull);
   assign sda_line = ~(dev_sda_oe | sda_pull);
   // ==========================================================
   // start: data falls while clock high, then clock low
   task bus_start();
      sda_pull = 1'b1;
      #100;
      scl_pull = 1'b1;
   endtask : bus_start
   // stop: clock rises, then data rises while clock high
   task bus_stop();
      sda_pull = 1'b1;
      #100;
      scl_pull = 1'b0;
      #100;
      sda_pull = 1'b0;
   endtask : bus_stop
endmodule : icr_bus_partner

// >>> sim/test_i2c_comm_reservation_low_width.sv
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for reservation and low width
module test_i2c_comm_reservation_low_width;
   logic sys_clk = 1'b0; // 40 MHz
   logic srst = 1'b1; // held for 8 cycles
   logic [19:0] cpu_addr = 20'h00000; // register address
   logic cpu_wr = 1'b0; // write strobe
   logic cpu_rd = 1'b0; // read strobe
   logic [7:0] cpu_wdata = 8'h00; // write data
   logic [7:0] cpu_rdata_q; // read data
   logic scl_oe_q, sda_oe_q, bus_event_irq_q; // device pulls and irq
   logic scl_out_q, sda_out_q; // open-drain output levels, always low
   logic scl_line, sda_line; // resolved wires
   int fail_count = 0; // mismatches
   int tests_run = 0; // comparisons
   int irq_n = 0; // irq pulses seen
   int low_m = 255; // model low width
   int high_m = 255; // model high width
   int en_m = 0; // model enable bit
   int lw, n, h, hx, i0; // scratch
   logic [7:0] rv; // last read value
   // ==========================================================
   // device and far side
   icr_top i_icr_top (.sys_clk(sys_clk), .srst(srst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
      .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata_q(cpu_rdata_q), .scl_in(scl_line),
      .scl_out_q(scl_out_q), .scl_oe_q(scl_oe_q), .sda_in(sda_line), .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q),
      .bus_event_irq_q(bus_event_irq_q));
   icr_bus_partner i_icr_bus_partner (.dev_scl_oe(scl_oe_q), .dev_sda_oe(sda_oe_q),
      .scl_line(scl_line), .sda_line(sda_line));
   // clock generator
   initial
   begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   // irq pulse counter
   always @(posedge sys_clk)
   begin
      if (bus_event_irq_q === 1'b1)
         irq_n++;
   end
   // ==========================================================
   // compare and report
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %s exp %0h seen %0h", what, exp, seen);
      end
   endtask : check
   // let k edges pass, settle after the last
   task step(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask : step
   // byte write, model keeps widths while enabled
   task wr(input logic [19:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      cpu_addr <= a;
      cpu_wdata <= d;
      cpu_wr <= 1'b1;
      @(posedge sys_clk);
      cpu_wr <= 1'b0;
      if (a == icr_pkg::ADDR_LOW && en_m == 0)
         low_m = d;
      if (a == icr_pkg::ADDR_HIGH && en_m == 0)
         high_m = d;
      if (a == icr_pkg::ADDR_CTL0)
         en_m = d[icr_pkg::CTL_ENABLE];
      // let the write edge settle before anyone looks at outputs
      #1;
   endtask : wr
   // byte read into rv
   task rd(input logic [19:0] a);
      @(posedge sys_clk);
      cpu_addr <= a;
      cpu_rd <= 1'b1;
      @(posedge sys_clk);
      cpu_rd <= 1'b0;
      step(1);
      rv = cpu_rdata_q;
   endtask : rd
   // bounded wait for a pull enable level, 0 clock 1 data
   task wait_pin(input int s, input logic v);
      int k;
      k = 0;
      while ((s ? sda_oe_q : scl_oe_q) !== v && k < 4000)
      begin
         step(1);
         k++;
      end
      check("pin wait", k < 4000, 1);
   endtask : wait_pin
   // verdict and end of run
   task print_verdict();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   // watchdog against a hang
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      print_verdict();
   end
   // ==========================================================
   // main sequence
   initial
   begin
      void'($urandom(67));
      repeat (8) @(posedge sys_clk);
      srst <= 1'b0;
      step(2);
      rd(icr_pkg::ADDR_LOW);
      check("low reset", rv, low_m);
      rd(icr_pkg::ADDR_HIGH);
      check("high reset", rv, high_m);
      rd(20'hF02FF);
      check("unmapped", rv, 0);
      // random low width kept short
      lw = 8 + 4 * ($urandom % 6);
      wr(icr_pkg::ADDR_LOW, lw[7:0]);
      wr(icr_pkg::ADDR_HIGH, 8'h08);
      wr(icr_pkg::ADDR_CTL0, 8'h90);
      wr(icr_pkg::ADDR_LOW, 8'h11);
      rd(icr_pkg::ADDR_LOW);
      check("low width", rv, low_m);
      // free bus: start then wait state
      wr(icr_pkg::ADDR_CTL0, 8'h92);
      step(low_m + high_m + 4);
      rd(icr_pkg::ADDR_STAT);
      check("master free", rv[7], 1);
      check("clock held", scl_oe_q, 1);
      check("start data", sda_oe_q, 1);
      check("clock out", scl_out_q, 0);
      check("data out", sda_out_q, 0);
      // byte A0: bit 7 released, bit 6 pulled low
      wr(icr_pkg::ADDR_SHIFT, 8'hA0);
      wait_pin(0, 0);
      wait_pin(0, 1);
      n = 0;
      h = 0;
      do
      begin
         n++;
         if (sda_oe_q !== 1'b1)
            h = n;
         step(1);
      end
      while (scl_oe_q === 1'b1 && n < 600);
      check("low phase", n, low_m + 1);
      hx = ((low_m >> 2) > 1) ? (low_m >> 2) : 1;
      // data moves at count hx, so hx + 1 low cycles still show the old bit
      check("hold", h, hx + 1);
      // leave the bus mid-byte
      wr(icr_pkg::ADDR_CTL0, 8'hD0);
      step(4);
      rd(icr_pkg::ADDR_STAT);
      check("left master", rv[7], 0);
      check("clock free", scl_oe_q, 0);
      // busy bus: reservation, early data dropped
      i_icr_bus_partner.bus_start();
      step(10);
      wr(icr_pkg::ADDR_CTL0, 8'h92);
      rd(icr_pkg::ADDR_STAT);
      check("pending", rv[7:6], 2'b01);
      wr(icr_pkg::ADDR_SHIFT, 8'h55);
      step(40);
      check("no early tx", sda_oe_q, 0);
      i0 = irq_n;
      i_icr_bus_partner.bus_stop();
      step(10);
      check("stop irq", irq_n - i0, 1);
      // address after the stop launches the transfer
      wr(icr_pkg::ADDR_SHIFT, 8'hA0);
      wait_pin(0, 1);
      wait_pin(0, 0);
      check("first bit", sda_oe_q, 0);
      rd(icr_pkg::ADDR_STAT);
      check("master resv", rv[7], 1);
      wr(icr_pkg::ADDR_CTL0, 8'hC0);
      // reservation disabled, stop irq masked
      wr(icr_pkg::ADDR_FLAG, 8'h01);
      step(4);
      i_icr_bus_partner.bus_start();
      step(10);
      wr(icr_pkg::ADDR_CTL0, 8'h82);
      rd(icr_pkg::ADDR_STAT);
      check("no resv", rv[7:6], 2'b00);
      i0 = irq_n;
      i_icr_bus_partner.bus_stop();
      step(10);
      check("irq masked", irq_n - i0, 0);
      print_verdict();
   end
endmodule : test_i2c_comm_reservation_low_width
